// ===== msr_loop_host.sv
/*
  Far-side model of the report port: a printer or host on the loop.
  Assumes the line idles at mark and one bit lasts BIT_CYC << (3-baud).
*/
`timescale 1ns/1ps
module msr_loop_host #(
  parameter int BIT_CYC = 8
) (
  // Clock and rate
  input wire logic core_clk,
  input wire logic [1:0] baud,
  // Loop lines
  input wire logic line_rx,
  output logic line_tx
);
  logic [7:0] q[$];

  // ----------------------------------------------------------------
  // Receiver and transmitter
  // ----------------------------------------------------------------
  // bit time follows the selected rate
  function automatic int bit_t();
    return (BIT_CYC / 8 * 8) << (3 - int'(baud));
  endfunction : bit_t

  // start, eight data bits, stop; sampled mid bit for margin
  initial begin
    logic [7:0] b;
    line_tx = 1'b1;
    forever begin
      @(posedge core_clk);
      if (line_rx === 1'b0) begin
        repeat (bit_t() / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (bit_t()) @(posedge core_clk);
          b[i] = line_rx;
        end
        repeat (bit_t()) @(posedge core_clk);
        if (line_rx !== 1'b1) b = 8'h00; // Framing error marker
        q.push_back(b);
      end
    end
  end

  // LSB first, line back at mark after the stop bit
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk);
      line_tx <= f[i];
      repeat (bit_t() - 1) @(posedge core_clk);
    end
  endtask : send
endmodule : msr_loop_host

// ===== msr_pkg.sv
/*
  Package of the meter serial report port: register map, field layout,
  reset values, report tables, character codes and the state record.
  Assumes a 250 MHz core clock and a 32-bit Avalon-MM register bus.
*/
package msr_pkg;

  // ----------------------------------------------------------------
  // Clock and line rates
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 250_000_000;
  localparam int BAUD_2400 = 2400;
  localparam int BIT_CYC_2400 = CLK_HZ / BAUD_2400;
  localparam int OVERSAMPLE = 8;        // Ticks per bit
  localparam logic [2:0] RX_MID = 3'h4; // Tick inside a bit to sample
  localparam logic [3:0] FRAME_BITS = 4'ha;
  localparam logic [6:0] LB_TMO_TICKS = 7'h60; // Twelve bit times

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATION = 8'h04;
  localparam logic [7:0] ADDR_SERVICE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_VALUE = 8'h20; // Nine words of values
  localparam logic [7:0] ADDR_VALUE_END = 8'h44; // One past the ninth word

  // Control fields
  localparam int CTRL_BAUD = 0;   // [1:0] 0=300 1=600 2=1200 3=2400
  localparam int CTRL_CODE = 4;   // [7:4] report code
  localparam int CTRL_FULL = 8;   // Full framing
  localparam int CTRL_REM1 = 9;   // Remote input one requests report
  localparam int CTRL_REM2 = 10;  // Remote input two requests report
  localparam logic [1:0] RST_BAUD = 2'h2;
  localparam logic [3:0] RST_CODE = 4'h0;
  localparam logic RST_FULL = 1'b1;
  localparam logic [6:0] RST_STATION = 7'h00;
  localparam logic [6:0] STATION_MAX = 7'h63;
  localparam logic [7:0] SVC_LOOPBACK = 8'h27;

  // Value word fields
  localparam int VAL_NEG = 24;
  localparam int VAL_OVF = 25;
  localparam int VAL_OVL = 26;
  localparam int VAL_UNL = 27;

  // ----------------------------------------------------------------
  // Report items: 0 input, 1 total, 2/3 alarms, 4/5 hysteresis,
  // 6 peak, 7 valley, 8 tare
  // ----------------------------------------------------------------
  localparam int NUM_ITEMS = 9;
  localparam logic [3:0] ITEM_INPUT = 4'h0;
  localparam logic [3:0] ITEM_TOTAL = 4'h1;
  localparam logic [3:0] ITEM_END = 4'h9;
  localparam logic [15:0][8:0] REP_MASK = '{
    9'h000, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000,
    9'h1ff, 9'h00f, 9'h00e, 9'h1c3, 9'h003, 9'h002,
    9'h1fd, 9'h00d, 9'h1c1, 9'h001};
  localparam logic [8:0][23:0] MNEM = '{
    "TAR", "VAL", "PEA", "HY2", "HY1", "AL2", "AL1", "TOT", "INP"};

  // Record positions
  localparam logic [4:0] POS_MNEM = 5'h03;
  localparam logic [4:0] POS_SP2 = 5'h06;
  localparam logic [4:0] POS_SIGN = 5'h07;
  localparam logic [4:0] POS_STAR = 5'h08;
  localparam logic [4:0] POS_DIG = 5'h09;
  localparam logic [4:0] POS_CR = 5'h0f;
  localparam logic [4:0] POS_LF = 5'h10;

  // Characters
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_O = 8'h4f;
  localparam logic [7:0] CH_U = 8'h55;
  localparam logic [7:0] CH_L = 8'h4c;
  localparam logic [7:0] CMD_ADDR = 8'h4e;   // Address command
  localparam logic [7:0] CMD_REPORT = 8'h50; // Report trigger
  localparam logic [7:0] LB_BYTE = 8'ha5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    REP_IDLE = 3'b001, REP_PICK = 3'b010, REP_SEND = 3'b100
  } msr_rep_t;
  typedef enum logic [2:0] {
    LB_IDLE = 3'b001, LB_RUN = 3'b010, LB_DONE = 3'b100
  } msr_lb_t;

  typedef struct packed {
    logic [1:0] baud;
    logic [3:0] code;
    logic full;
    logic [1:0] rem_en;
    logic [6:0] station;
    logic [8:0][31:0] val;
    logic waitreq;
    logic [31:0] rdata;
    logic [16:0] tick_cnt;
    logic [2:0] tx_sub;
    logic [3:0] tx_bits;
    logic [8:0] tx_sh;
    logic tx_busy;
    logic tx_out;
    logic [7:0] cur_byte;
    msr_rep_t rep;
    logic [3:0] item;
    logic [4:0] pos;
    logic rx_busy;
    logic rx_prev;
    logic [2:0] rx_sub;
    logic [3:0] rx_bits;
    logic [7:0] rx_sh;
    logic [1:0] rem_prev;
    logic key_prev;
    logic addr_wait;
    logic addr_second;
    logic [3:0] addr_tens;
    logic addr_ok;
    msr_lb_t lb;
    logic [6:0] lb_tmo;
    logic pass;
    logic fail;
  } msr_state_t;

endpackage : msr_pkg

// ===== msr_report_port.sv
/*
  Serial report port: Avalon-MM register slave, bit-rate divider,
  asynchronous transmitter and receiver, report sequencer, command
  parser and loop-back self test, all in one state record.
  Assumes pins already synchronous to core_clk and an idle-high line.
*/
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
// Behaviour
// - The link runs at one selectable rate of 300, 600, 1200 or 2400 baud.
// - A station number of 0 to 99 is held; zero answers without addressing.
// - A report starts on an enabled remote input or the trigger character.
// - Items of options not fitted are left out of every report.
// - A total overflow puts an asterisk before the digits, after any minus.
// - An overloaded input sends OLOLOL, an underloaded one ULULUL.
// - Codes 0 to 3 select input, peak/valley/tare, alarms, hysteresis.
// - Codes 4 to 9 select total-based reports up to everything.
// - Abbreviated framing drops station, mnemonic and spacing.
// - Records end with CR LF; full framing leads with station, mnemonic.
// - Service code 39 runs a loop-back test showing pass or fail.
`timescale 1ns/1ps
module msr_report_port
  import msr_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYC_2400
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Current loop and panel pins
  input wire logic serial_in,
  output logic serial_out,
  input wire logic remote_input_one_n,
  input wire logic remote_input_two_n,
  input wire logic key_p,
  input wire logic option_alarm,
  input wire logic option_total,
  // Self-test result
  output logic test_pass,
  output logic test_fail
);

  localparam int TICK_2400 = BIT_CYC / OVERSAMPLE;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Tick length for a rate; each halving of the rate doubles it
  function automatic logic [16:0] tick_len(input logic [1:0] sel);
    logic [16:0] base;
    base = 17'(TICK_2400);
    return base << (2'h3 - sel);
  endfunction : tick_len

  function automatic logic item_fit(input logic [3:0] i, input logic al,
                                    input logic tot);
    logic r;
    r = 1'b1;
    if (i == ITEM_TOTAL) begin
      r = tot;
    end else if (i >= 4'h2 && i <= 4'h5) begin
      r = al;
    end
    return r;
  endfunction : item_fit

  // Character at a record position, MSB set when skipped
  function automatic logic [8:0] rec_char(input logic [4:0] pos,
      input logic [3:0] item, input logic [31:0] v,
      input logic [6:0] stn, input logic full);
    logic [8:0] r;
    logic [2:0] d;
    logic [3:0] bcd;
    logic [6:0] tens;
    r = {1'b1, CH_SP};
    d = 3'(pos - POS_DIG);
    bcd = v[4*(5-d) +: 4];
    tens = stn / 7'd10;
    if (pos < POS_SIGN) begin
      r[8] = !full;
      case (pos)
        5'h00: r[7:0] = CH_ZERO | {4'h0, tens[3:0]};
        5'h01: r[7:0] = CH_ZERO | {4'h0, 4'(stn - tens * 7'd10)};
        5'h02, POS_SP2: r[7:0] = CH_SP;
        default: r[7:0] = MNEM[item][8*(2-(pos-POS_MNEM)) +: 8];
      endcase
    end else if (pos == POS_SIGN) begin
      r = {!(v[VAL_NEG] || full), v[VAL_NEG] ? CH_MINUS : CH_SP};
    end else if (pos == POS_STAR) begin
      r = {!(v[VAL_OVF] && item == ITEM_TOTAL), CH_STAR};
    end else if (pos < POS_CR) begin
      if (item == ITEM_INPUT && (v[VAL_OVL] || v[VAL_UNL])) begin
        r = {1'b0, d[0] ? CH_L : (v[VAL_OVL] ? CH_O : CH_U)};
      end else begin
        r = {1'b0, CH_ZERO | {4'h0, bcd}};
      end
    end else begin
      r = {1'b0, pos == POS_CR ? CH_CR : CH_LF};
    end
    return r;
  endfunction : rec_char

  msr_state_t s_q;
  msr_state_t s_d;
  logic tick;
  logic [8:0] rc;
  logic [8:0] mask;
  logic trig_pin;
  logic trig_cmd;
  logic rx_done;

  assign tick = (s_q.tick_cnt == tick_len(s_q.baud) - 17'h1);
  assign rc = rec_char(s_q.pos, s_q.item, s_q.val[s_q.item], s_q.station,
                       s_q.full);
  assign mask = REP_MASK[s_q.code];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    trig_pin = 1'b0;
    trig_cmd = 1'b0;
    rx_done = 1'b0;
    s_d.rx_prev = serial_in;
    s_d.rem_prev = {remote_input_two_n, remote_input_one_n};
    s_d.key_prev = key_p;

    // bit-rate divider, one tick per eighth of a bit
    s_d.tick_cnt = tick ? 17'h0 : s_q.tick_cnt + 17'h1;

    // Register bus: one wait cycle, then the access completes
    if ((read || write) && s_q.waitreq) begin
      s_d.waitreq = 1'b0;
      s_d.rdata = 32'h0000_0000;
      case (address)
        ADDR_CTRL: s_d.rdata = 32'({s_q.rem_en, s_q.full, s_q.code,
                                     2'h0, s_q.baud});
        ADDR_STATION: s_d.rdata = 32'(s_q.station);
        ADDR_STATUS: s_d.rdata = {16'h0000, s_q.rx_sh, 4'h0,
            s_q.fail, s_q.pass, s_q.lb != LB_IDLE, s_q.rep != REP_IDLE};
        default: begin
          if (address >= ADDR_VALUE && address < ADDR_VALUE_END &&
              address[1:0] == 2'h0) begin
            s_d.rdata = s_q.val[4'((address - ADDR_VALUE) >> 2)];
          end
        end
      endcase
    end else if (!s_q.waitreq) begin
      s_d.waitreq = 1'b1;
      if (write) begin
        case (address)
          ADDR_CTRL: begin
            s_d.baud = writedata[CTRL_BAUD +: 2];
            s_d.code = writedata[CTRL_CODE +: 4];
            s_d.full = writedata[CTRL_FULL];
            s_d.rem_en = writedata[CTRL_REM1 +: 2];
            // Restart divider: a shorter tick would otherwise only match after the count wraps
            s_d.tick_cnt = 17'h0;
          end
          ADDR_STATION: begin
            if (writedata <= 32'(STATION_MAX)) begin
              s_d.station = writedata[6:0];
            end
          end
          ADDR_SERVICE: begin
            if (writedata[7:0] == SVC_LOOPBACK && s_q.lb == LB_IDLE &&
                s_q.rep == REP_IDLE && !s_q.tx_busy) begin
              s_d.lb = LB_RUN;
              s_d.lb_tmo = 7'h00;
              s_d.pass = 1'b0;
              s_d.fail = 1'b0;
              s_d.tx_busy = 1'b1;
              s_d.tx_out = 1'b0;
              s_d.tx_sh = {1'b1, LB_BYTE};
              s_d.tx_bits = 4'h0;
              s_d.tx_sub = 3'h0;
              s_d.cur_byte = LB_BYTE;
            end
          end
          default: begin
            if (address >= ADDR_VALUE && address < ADDR_VALUE_END &&
                address[1:0] == 2'h0) begin
              s_d.val[4'((address - ADDR_VALUE) >> 2)] = writedata;
            end
          end
        endcase
      end
    end

    // transmitter: start, eight data, stop, idle at mark
    if (s_q.tx_busy && tick) begin
      s_d.tx_sub = s_q.tx_sub + 3'h1;
      if (s_q.tx_sub == 3'h7) begin
        s_d.tx_out = s_q.tx_sh[0];
        s_d.tx_sh = {1'b1, s_q.tx_sh[8:1]};
        s_d.tx_bits = s_q.tx_bits + 4'h1;
        if (s_q.tx_bits == FRAME_BITS - 4'h1) begin
          s_d.tx_busy = 1'b0;
          s_d.tx_out = 1'b1;
        end
      end
    end

    // Receiver, sampled mid-bit
    if (!s_q.rx_busy) begin
      if (s_q.rx_prev && !serial_in) begin
        s_d.rx_busy = 1'b1;
        s_d.rx_sub = 3'h0;
        s_d.rx_bits = 4'h0;
      end
    end else if (tick) begin
      s_d.rx_sub = s_q.rx_sub + 3'h1;
      if (s_q.rx_sub == RX_MID) begin
        s_d.rx_bits = s_q.rx_bits + 4'h1;
        if (s_q.rx_bits == 4'h0 && serial_in) begin
          s_d.rx_busy = 1'b0;            // Glitch, not a start bit
        end else if (s_q.rx_bits == FRAME_BITS - 4'h1) begin
          s_d.rx_busy = 1'b0;
          rx_done = serial_in;           // Framing error drops the byte
        end else if (s_q.rx_bits != 4'h0) begin
          s_d.rx_sh = {serial_in, s_q.rx_sh[7:1]};
        end
      end
    end

    // address command: letter then two decimal digits
    if (rx_done && s_q.lb == LB_IDLE) begin
      if (s_q.addr_wait) begin
        if (!s_q.addr_second) begin
          s_d.addr_tens = s_q.rx_sh[3:0];
          s_d.addr_second = 1'b1;
        end else begin
          s_d.addr_wait = 1'b0;
          s_d.addr_ok = (7'(s_q.addr_tens) * 7'd10 + 7'(s_q.rx_sh[3:0])
                         == s_q.station);
        end
      end else if (s_q.rx_sh == CMD_ADDR) begin
        s_d.addr_wait = 1'b1;
        s_d.addr_second = 1'b0;
        s_d.addr_ok = 1'b0;
      end else if (s_q.rx_sh == CMD_REPORT) begin
        trig_cmd = (s_q.station == 7'h00) || s_q.addr_ok;
        s_d.addr_ok = 1'b0;
      end
    end

    // remote inputs start a report on their falling edge
    trig_pin = (s_q.rem_en[0] && s_q.rem_prev[0] && !remote_input_one_n) ||
               (s_q.rem_en[1] && s_q.rem_prev[1] && !remote_input_two_n);

    // Report sequencer
    case (s_q.rep)
      REP_IDLE: begin
        if ((trig_pin || trig_cmd) && s_q.lb == LB_IDLE && !s_q.tx_busy) begin
          s_d.rep = REP_PICK;
          s_d.item = 4'h0;
          s_d.pos = 5'h00;
        end
      end
      REP_PICK: begin
        if (s_q.item == ITEM_END) begin
          s_d.rep = REP_IDLE;
        end else if (!mask[s_q.item] ||
                     !item_fit(s_q.item, option_alarm, option_total)) begin
          s_d.item = s_q.item + 4'h1;
        // skipped positions cost no line time
        end else if (rc[8]) begin
          s_d.pos = s_q.pos + 5'h01;
        end else begin
          s_d.rep = REP_SEND;
          s_d.tx_busy = 1'b1;
          s_d.tx_out = 1'b0;
          s_d.tx_sh = {1'b1, rc[7:0]};
          s_d.tx_bits = 4'h0;
          s_d.tx_sub = 3'h0;
          s_d.cur_byte = rc[7:0];
        end
      end
      REP_SEND: begin
        if (!s_q.tx_busy) begin
          s_d.rep = REP_PICK;
          // record closes after the line feed
          if (s_q.pos == POS_LF) begin
            s_d.pos = 5'h00;
            s_d.item = s_q.item + 4'h1;
          end else begin
            s_d.pos = s_q.pos + 5'h01;
          end
        end
      end
      default: s_d.rep = REP_IDLE;
    endcase

    // loop-back check and result hold until a key press
    case (s_q.lb)
      LB_IDLE: ;
      LB_RUN: begin
        if (tick) begin
          s_d.lb_tmo = s_q.lb_tmo + 7'h01;
        end
        if (rx_done) begin
          s_d.lb = LB_DONE;
          s_d.pass = (s_q.rx_sh == LB_BYTE);
          s_d.fail = (s_q.rx_sh != LB_BYTE);
        end else if (s_q.lb_tmo == LB_TMO_TICKS) begin
          s_d.lb = LB_DONE;
          s_d.fail = 1'b1;
        end
      end
      LB_DONE: begin
        if (key_p && !s_q.key_prev) begin
          s_d.lb = LB_IDLE;
          s_d.pass = 1'b0;
          s_d.fail = 1'b0;
        end
      end
      default: s_d.lb = LB_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.baud <= RST_BAUD;
      s_q.code <= RST_CODE;
      s_q.full <= RST_FULL;
      s_q.station <= RST_STATION;
      s_q.waitreq <= 1'b1;
      s_q.tx_out <= 1'b1;
      s_q.tx_sh <= '1;
      s_q.rx_prev <= 1'b1;
      s_q.rem_prev <= 2'h3;
      s_q.rep <= REP_IDLE;
      s_q.lb <= LB_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign readdata = s_q.rdata;
  assign waitrequest = s_q.waitreq;
  assign serial_out = s_q.tx_out;
  assign test_pass = s_q.pass;
  assign test_fail = s_q.fail;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  chk_tick_bound: assert property (
    s_q.tick_cnt < tick_len(s_q.baud)) else $error("tick count overrun");
  chk_station_range: assert property (
    s_q.station <= STATION_MAX) else $error("station out of range");
  chk_pin_start: assert property (
    s_q.rep == REP_IDLE && s_q.lb == LB_IDLE && !s_q.tx_busy &&
    s_q.rem_en[0] && s_q.rem_prev[0] && !remote_input_one_n
    |=> s_q.rep == REP_PICK) else $error("remote request ignored");
  chk_fitted_only: assert property (
    s_q.rep == REP_SEND |-> mask[s_q.item] &&
    item_fit(s_q.item, option_alarm, option_total))
    else $error("unfitted item sent");
  chk_star_char: assert property (
    $rose(s_q.rep == REP_SEND) && s_q.pos == POS_STAR
    |-> s_q.cur_byte == CH_STAR && s_q.item == ITEM_TOTAL)
    else $error("bad overflow mark");
  chk_overload_text: assert property (
    $rose(s_q.rep == REP_SEND) && s_q.item == ITEM_INPUT &&
    s_q.val[0][VAL_OVL] && s_q.pos == POS_DIG |-> s_q.cur_byte == CH_O)
    else $error("overload text wrong");
  chk_abbrev_skip: assert property (
    s_q.rep == REP_SEND && !s_q.full |-> s_q.pos >= POS_SIGN)
    else $error("header sent in abbreviated mode");
  chk_record_end: assert property (
    $rose(s_q.rep == REP_SEND) && s_q.pos == POS_CR
    |-> s_q.cur_byte == CH_CR) else $error("record end not CR");
  chk_lb_result: assert property (
    s_q.lb == LB_RUN && s_q.lb_tmo == LB_TMO_TICKS && !rx_done
    |=> s_q.fail && !s_q.pass) else $error("loop-back timeout lost");
  chk_addr_gate: assert property (
    trig_cmd |-> s_q.station == 7'h00 || s_q.addr_ok)
    else $error("unaddressed trigger taken");
  chk_frame_shape: assert property (
    $rose(s_q.tx_busy) |=> !serial_out [*2]) else $error("no start bit");

endmodule : msr_report_port

// ===== msr_report_port_tb.sv
/*
  Testbench of the serial report port: bus tasks and report runs.
  Assumes the far-side model msr_loop_host and BIT_CYC of 8.
*/
`timescale 1ns/1ps
module msr_report_port_tb
  import msr_pkg::*;
;
  logic core_clk, rst, read, write, key_p, loop_on, host_tx, serial_in;
  logic remote_input_one_n, remote_input_two_n, option_alarm, option_total;
  logic [7:0] address;
  logic [31:0] writedata, readdata, rd;
  logic waitrequest, serial_out, test_pass, test_fail;
  logic [1:0] baud;
  int errors, checks;
  // Item bits per report code, input in bit 0
  logic [8:0] mask [10] = '{9'h001, 9'h1c1, 9'h00d, 9'h1fd, 9'h002,
    9'h003, 9'h1c3, 9'h00e, 9'h00f, 9'h1ff};

  // External loop-back plug for the self test
  assign serial_in = loop_on ? serial_out : host_tx;

  msr_report_port #(.BIT_CYC(8)) u_dut (.core_clk(core_clk), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .serial_in(serial_in),
    .serial_out(serial_out), .remote_input_one_n(remote_input_one_n),
    .remote_input_two_n(remote_input_two_n), .key_p(key_p),
    .option_alarm(option_alarm), .option_total(option_total),
    .test_pass(test_pass), .test_fail(test_fail));

  msr_loop_host #(.BIT_CYC(8)) u_host (.core_clk(core_clk), .baud(baud),
    .line_rx(serial_out), .line_tx(host_tx));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic give_up();
    errors++;
    print_verdict();
  endtask : give_up

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 40) give_up();
  endtask : bus

  function automatic logic [31:0] ctl(input logic [1:0] b,
    input logic [3:0] c, input logic f, input logic [1:0] e);
    return {21'h0, e, f, c, 2'h0, b};
  endfunction : ctl

  task automatic pulse(input int which);
    @(posedge core_clk);
    if (which == 1) remote_input_one_n <= 1'b0;
    else remote_input_two_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    remote_input_one_n <= 1'b1;
    remote_input_two_n <= 1'b1;
  endtask : pulse

  task automatic expect_rec(input string s);
    int n;
    for (int i = 0; i < s.len(); i++) begin
      n = 0;
      while (u_host.q.size() == 0 && n < 3000) begin
        @(posedge core_clk);
        n++;
      end
      if (n >= 3000) give_up();
      chk("record char", {24'h0, s[i]}, {24'h0, u_host.q.pop_front()});
    end
  endtask : expect_rec

  // Waits out report and line so the next trigger is not dropped
  task automatic idle();
    int n;
    n = 0;
    do begin
      bus(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (rd[1:0] !== 2'h0 && n < 500);
    if (n >= 500) give_up();
    repeat (100) @(posedge core_clk);
    chk("stray bytes", 32'h0, 32'(u_host.q.size()));
  endtask : idle

  task automatic wait_test();
    int n;
    n = 0;
    while (test_pass !== 1'b1 && test_fail !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 3000) give_up();
  endtask : wait_test

  // ----------------------------------------------------------------
  // Clock and sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  initial begin
    rst = 1'b1;
    {read, write, key_p, loop_on} = 4'h0;
    {remote_input_one_n, remote_input_two_n} = 2'h3;
    {option_alarm, option_total} = 2'h3;
    address = 8'h00;
    writedata = 32'h0;
    baud = 2'h2;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", 32'h0000_0102, rd);
    bus(1'b0, 8'h80, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, ADDR_STATION, 32'h0000_0064);
    bus(1'b0, ADDR_STATION, 32'h0);
    chk("station over", 32'h0, rd);
    bus(1'b1, ADDR_STATION, 32'h0000_0063);
    bus(1'b0, ADDR_STATION, 32'h0);
    chk("station max", 32'h0000_0063, rd);
    bus(1'b1, ADDR_STATION, 32'h0);
    for (int i = 0; i < 9; i++)
      bus(1'b1, ADDR_VALUE + 8'(4 * i), 32'h0000_0100 + 32'(i));
    for (int b = 0; b < 4; b++) begin
      baud <= 2'(b);
      bus(1'b1, ADDR_CTRL, ctl(2'(b), 4'h0, 1'b0, 2'h1));
      pulse(1);
      expect_rec("000100\r\n");
      idle();
    end
    for (int c = 0; c < 10; c++) begin
      bus(1'b1, ADDR_CTRL, ctl(2'h3, 4'(c), 1'b0, 2'h2));
      pulse(2);
      for (int i = 0; i < 9; i++)
        if (mask[c][i]) expect_rec($sformatf("00010%0d\r\n", i));
      idle();
    end
    option_alarm <= 1'b0;
    option_total <= 1'b0;
    pulse(2);
    expect_rec("000100\r\n000106\r\n000107\r\n000108\r\n");
    idle();
    option_total <= 1'b1;
    bus(1'b1, ADDR_VALUE, 32'h0400_0100);
    bus(1'b1, ADDR_VALUE + 8'h04, 32'h0300_0127);
    bus(1'b1, ADDR_CTRL, ctl(2'h3, 4'h5, 1'b0, 2'h0));
    u_host.send(CMD_REPORT);
    expect_rec("OLOLOL\r\n-*000127\r\n");
    idle();
    bus(1'b1, ADDR_VALUE, 32'h0800_0100);
    bus(1'b1, ADDR_CTRL, ctl(2'h3, 4'h0, 1'b0, 2'h0));
    u_host.send(CMD_REPORT);
    expect_rec("ULULUL\r\n");
    idle();
    bus(1'b1, ADDR_VALUE, 32'h0100_0100);
    bus(1'b1, ADDR_CTRL, ctl(2'h3, 4'h0, 1'b1, 2'h0));
    u_host.send(CMD_REPORT);
    expect_rec("00 INP -000100\r\n");
    idle();
    bus(1'b1, ADDR_VALUE, 32'h0000_0100);
    bus(1'b1, ADDR_STATION, 32'h0000_0005);
    u_host.send(CMD_REPORT);
    repeat (400) @(posedge core_clk);
    chk("unaddressed", 32'h0, 32'(u_host.q.size()));
    u_host.send(CMD_ADDR);
    u_host.send(8'h30);
    u_host.send(8'h35);
    u_host.send(CMD_REPORT);
    expect_rec("05 INP  000100\r\n");
    idle();
    loop_on <= 1'b1;
    bus(1'b1, ADDR_SERVICE, 32'h0000_0027);
    wait_test();
    chk("test pass", 32'h1, {31'h0, test_pass});
    key_p <= 1'b1;
    repeat (4) @(posedge core_clk);
    key_p <= 1'b0;
    chk("pass cleared", 32'h0, {31'h0, test_pass});
    loop_on <= 1'b0;
    bus(1'b1, ADDR_SERVICE, 32'h0000_0027);
    wait_test();
    chk("test fail", 32'h1, {31'h0, test_fail});
    print_verdict();
  end
endmodule : msr_report_port_tb
